// File: hdl/ddp_params.svh
// Purpose: Offsets, field positions, reset values and counts of the port
// Assumes: Included by the package and by the port design file
// Notes: Definitions only
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH
// ==========================================
// Register offsets
`define DDP_OFS_CLK 5'h05
`define DDP_OFS_GAIN 5'h0B
`define DDP_OFS_TXF 5'h0C
`define DDP_OFS_RXF 5'h0D
`define DDP_OFS_DRV 5'h0E
// ==========================================
// Reset values
`define DDP_RST_REG 8'h00
`define DDP_RST_GAIN 8'h04
// ==========================================
// Field positions
`define DDP_B_TWOS 0
`define DDP_B_NEG 1
`define DDP_B_LSF 2
`define DDP_B_FIVE 3
`define DDP_B_INV 4
`define DDP_B_TRI 5
`define DDP_B_DRV 7
`define DDP_B_CKDIS 0
`define DDP_B_CKINV 1
`define DDP_B_OSC 2
`define DDP_B_RXGAIN 2
`define DDP_B_SWGAIN 3
// ==========================================
// Counts in link clock cycles, FIFO depth in entries
`define DDP_FLUSH_CYC 6'd33
`define DDP_RX_LAT 3'd6
`define DDP_FIFO_DEPTH 4'd5
`endif

// File: hdl/ddp_pkg.sv
// Purpose: Types shared by the duplex data port
// Assumes: Constants come from the params header
// Notes: Format decode is used for both directions
`include "ddp_params.svh"
package ddp_pkg;
    typedef struct packed {logic valid; logic [9:0] data;} ddp_word_t;
    typedef struct packed {
        logic tri_st; logic inv; logic five; logic lsf; logic neg;
        logic twos;
    } ddp_fmt_t;
    typedef struct packed {
        logic [9:0] bus; logic [5:0] nib; logic sync; logic txg;
        logic rxg; logic gain;
    } ddp_pins_t;
    typedef struct packed {
        logic [9:0] bus; logic oe_n; logic [5:0] nib; logic sync;
    } ddp_rxo_t;
    typedef enum logic [1:0] {RX_OFF, RX_FILL, RX_DRIVE} ddp_rx_st_t;
    // Decode one format register
    function automatic ddp_fmt_t ddp_fmt(input logic [7:0] r);
        ddp_fmt = {r[`DDP_B_TRI], r[`DDP_B_INV], r[`DDP_B_FIVE],
                   r[`DDP_B_LSF], r[`DDP_B_NEG], r[`DDP_B_TWOS]};
    endfunction
endpackage

// File: hdl/ddp_port.sv
// Purpose: Half/full duplex data port between converters and baseband
// Assumes: i_port_clk is the bus clock in both modes
// Notes: Registers written over a decoded byte-wide register port
`timescale 1ns/1ps
`include "ddp_params.svh"

// ==========================================
// Five-entry dual clock FIFO
module ddp_afifo import ddp_pkg::*; (
    input wire logic i_wclk,
    input wire logic i_wrst_b,
    input wire logic i_push,
    input wire logic [9:0] i_wdata,
    output logic o_full,
    input wire logic i_rclk,
    input wire logic i_rrst_b,
    input wire logic i_pop,
    output logic [9:0] o_rdata,
    output logic o_empty
);
    logic [9:0] mem_q [8];
    logic [3:0] wbin_q, wg_q, rbin_q, rg_q;
    logic [3:0] rg1_q, rg2_q, wg1_q, wg2_q;
    logic [3:0] wn, rn;

    function automatic logic [3:0] g2b(input logic [3:0] g);
        g2b = {g[3], ^g[3:2], ^g[3:1], ^g};
    endfunction

    // Occupancy limit gives five entries over gray pointers
    assign o_full = 4'(wbin_q - g2b(rg2_q)) >= `DDP_FIFO_DEPTH;
    assign o_empty = rg_q == wg2_q;
    assign o_rdata = mem_q[rbin_q[2:0]];
    assign wn = wbin_q + 4'h1;
    assign rn = rbin_q + 4'h1;

    // Write side and read pointer synchroniser
    always_ff @(posedge i_wclk) begin
        if (!i_wrst_b) begin
            wbin_q <= 4'h0;
            wg_q <= 4'h0;
            rg1_q <= 4'h0;
            rg2_q <= 4'h0;
        end else begin
            rg1_q <= rg_q;
            rg2_q <= rg1_q;
            if (i_push && !o_full) begin
                mem_q[wbin_q[2:0]] <= i_wdata;
                wbin_q <= wn;
                wg_q <= wn ^ (wn >> 1);
            end
        end
    end

    // Read side and write pointer synchroniser
    always_ff @(posedge i_rclk) begin
        if (!i_rrst_b) begin
            rbin_q <= 4'h0;
            rg_q <= 4'h0;
            wg1_q <= 4'h0;
            wg2_q <= 4'h0;
        end else begin
            wg1_q <= wg_q;
            wg2_q <= wg1_q;
            if (i_pop && !o_empty) begin
                rbin_q <= rn;
                rg_q <= rn ^ (rn >> 1);
            end
        end
    end

    push_adv_a: assert property (@(posedge i_wclk) disable iff (!i_wrst_b)
        (i_push && !o_full) |=> wbin_q == 4'($past(wbin_q) + 4'h1))
        else $error("fifo write pointer did not advance");
endmodule // ddp_afifo

// ==========================================
// Duplex data port
module ddp_port import ddp_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_port_clk,
    input wire logic i_oscillator_input,
    input wire logic i_mode_strap,
    input wire logic i_reg_wr,
    input wire logic [4:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [9:0] i_shared_data_bus,
    output logic [9:0] o_shared_data_bus,
    output logic o_shared_data_bus_oe_n,
    input wire logic i_transmit_gate,
    input wire logic i_receive_gate,
    input wire logic [5:0] i_tx_nibble,
    input wire logic i_transmit_nibble_sync,
    input wire logic i_gain_strobe,
    output logic [5:0] o_rx_nibble,
    output logic o_receive_nibble_sync,
    output logic o_receive_port_clock,
    output logic o_low_drive,
    output logic [5:0] o_receive_gain_amp,
    output ddp_word_t o_tx_word,
    input wire logic i_tx_ready,
    input wire ddp_word_t i_rx_word,
    output logic o_rx_ready
);
    logic [7:0] clk_q, gain_q, txf_q, rxf_q, drv_q;
    logic lk_rs1_q, lk_rst_b_q, lk_m1_q, lk_mode_q;
    logic [23:0] lk_c1_q, lk_c_q;
    ddp_fmt_t tf, rf;
    ddp_pins_t pin_now, pin_neg_q, tp, rp;
    ddp_rxo_t rxo_q, rxo_neg_q, rxo;
    logic txg, rxg, txg_q, s, lo_q, rep_q, tx_push, gld;
    logic [5:0] fl_q, first_q, ms, ls, rgain_q, hold_q;
    logic [9:0] tx_word, last_q, fdw, rxw;
    logic tx_full, tx_empty, rx_full, rx_empty, rx_pop, ph_q, rx_on;
    logic [9:0] tx_rdata, rx_head;
    logic [2:0] cnt_q;
    ddp_rx_st_t st_q;

    // ==========================================
    // Register file, core clock
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            clk_q <= `DDP_RST_REG;
            gain_q <= `DDP_RST_GAIN;
            txf_q <= `DDP_RST_REG;
            rxf_q <= `DDP_RST_REG;
            drv_q <= `DDP_RST_REG;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `DDP_OFS_CLK: clk_q <= i_reg_wdata;
                `DDP_OFS_GAIN: gain_q <= i_reg_wdata;
                `DDP_OFS_TXF: txf_q <= i_reg_wdata;
                `DDP_OFS_RXF: rxf_q <= i_reg_wdata;
                `DDP_OFS_DRV: drv_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Registered read, unmapped reads zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `DDP_OFS_CLK: o_reg_rdata <= clk_q;
                `DDP_OFS_GAIN: o_reg_rdata <= gain_q;
                `DDP_OFS_TXF: o_reg_rdata <= txf_q;
                `DDP_OFS_RXF: o_reg_rdata <= rxf_q;
                `DDP_OFS_DRV: o_reg_rdata <= drv_q;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    assign o_low_drive = drv_q[`DDP_B_DRV];

    // Core side of the FIFOs
    assign o_tx_word = {!tx_empty, tx_rdata};
    assign o_rx_ready = !rx_full;

    // ==========================================
    // Link domain reset, strap and config crossing
    always_ff @(posedge i_port_clk) begin
        lk_rs1_q <= i_rst_b;
        lk_rst_b_q <= lk_rs1_q;
        lk_m1_q <= i_mode_strap;
        lk_mode_q <= lk_m1_q;
        lk_c1_q <= {gain_q, txf_q, rxf_q};
        lk_c_q <= lk_c1_q;
    end

    assign tf = ddp_fmt(lk_c_q[15:8]);
    assign rf = ddp_fmt(lk_c_q[7:0]);
    assign pin_now = {i_shared_data_bus, i_tx_nibble,
        i_transmit_nibble_sync, i_transmit_gate, i_receive_gate,
        i_gain_strobe};

    // Falling edge samples of all link inputs
    always_ff @(negedge i_port_clk) begin
        pin_neg_q <= pin_now;
    end

    // Edge choice per direction
    assign tp = tf.neg ? pin_neg_q : pin_now;
    assign rp = rf.neg ? pin_neg_q : pin_now;
    assign txg = tp.txg ^ tf.inv;
    assign rxg = rp.rxg ^ rf.inv;
    assign s = tp.sync ^ tf.inv;

    // Nibble join, upper first unless low first selected
    assign ms = tf.lsf ? tp.nib : first_q;
    assign ls = tf.lsf ? first_q : tp.nib;
    assign fdw = tf.five ? {ms[5:1] ^ {tf.twos, 4'h0}, ls[5:1]}
        : {ms[5] ^ tf.twos, ms[4:0], ls[3:0]};
    assign gld = lk_mode_q && !s && lk_c_q[16 + `DDP_B_RXGAIN]
        && (tp.gain || lk_c_q[16 + `DDP_B_SWGAIN]);

    // ==========================================
    // Transmit word selection
    always_comb begin
        tx_push = 1'b0;
        tx_word = 10'h000;
        if (!lk_mode_q) begin
            if (txg && !rxg) begin
                tx_push = 1'b1;
                tx_word = {tp.bus[9] ^ !tf.twos, tp.bus[8:0]};
            end else if (fl_q != 6'd0) begin
                tx_push = 1'b1;
            end
        end else if (s) begin
            tx_push = 1'b1;
            tx_word = fdw;
        end else if (lo_q && !rep_q) begin
            tx_push = 1'b1;
            tx_word = last_q;
        end
    end

    // Flush counter, nibble history and gain load
    always_ff @(posedge i_port_clk) begin
        if (!lk_rst_b_q) begin
            txg_q <= 1'b0;
            fl_q <= 6'd0;
            first_q <= 6'h00;
            lo_q <= 1'b0;
            rep_q <= 1'b0;
            last_q <= 10'h000;
            rgain_q <= 6'h00;
        end else begin
            txg_q <= txg;
            if (!lk_mode_q && txg_q && !txg) begin
                fl_q <= `DDP_FLUSH_CYC;
            end else if (txg || fl_q == 6'd0) begin
                fl_q <= 6'd0;
            end else begin
                fl_q <= fl_q - 6'd1;
            end
            lo_q <= !s;
            rep_q <= !s && lo_q && !rep_q;
            if (!s) begin
                first_q <= tp.nib;
            end
            if (tx_push) begin
                last_q <= tx_word;
            end
            if (gld) begin
                rgain_q <= tp.nib;
            end
        end
    end

    assign o_receive_gain_amp = rgain_q;

    ddp_afifo u_tx_fifo (
        .i_wclk(i_port_clk),
        .i_wrst_b(lk_rst_b_q),
        .i_push(tx_push),
        .i_wdata(tx_word),
        .o_full(tx_full),
        .i_rclk(i_core_clk),
        .i_rrst_b(i_rst_b),
        .i_pop(i_tx_ready),
        .o_rdata(tx_rdata),
        .o_empty(tx_empty)
    );

    ddp_afifo u_rx_fifo (
        .i_wclk(i_core_clk),
        .i_wrst_b(i_rst_b),
        .i_push(i_rx_word.valid),
        .i_wdata(i_rx_word.data),
        .o_full(rx_full),
        .i_rclk(i_port_clk),
        .i_rrst_b(lk_rst_b_q),
        .i_pop(rx_pop),
        .o_rdata(rx_head),
        .o_empty(rx_empty)
    );

    // ==========================================
    // Receive path
    assign rx_on = !lk_mode_q && rxg;
    // Half duplex pops only once the fill delay has passed
    assign rx_pop = lk_mode_q ? !ph_q : st_q == RX_DRIVE;
    assign rxw = {rx_head[9] ^ (lk_mode_q ? rf.twos : !rf.twos),
        rx_head[8:0]};

    // Half duplex enable sequence
    always_ff @(posedge i_port_clk) begin
        if (!lk_rst_b_q) begin
            st_q <= RX_OFF;
            cnt_q <= 3'd0;
        end else begin
            case (st_q)
                RX_OFF: if (rx_on) begin
                    st_q <= RX_FILL;
                    cnt_q <= 3'd1;
                end
                RX_FILL: if (!rx_on) begin
                    st_q <= RX_OFF;
                end else if (cnt_q == `DDP_RX_LAT - 3'd1) begin
                    st_q <= RX_DRIVE;
                end else begin
                    cnt_q <= cnt_q + 3'd1;
                end
                RX_DRIVE: if (!rx_on) begin
                    st_q <= RX_OFF;
                end
                default: st_q <= RX_OFF;
            endcase
        end
    end

    // Output registers for both modes
    always_ff @(posedge i_port_clk) begin
        if (!lk_rst_b_q) begin
            rxo_q <= '{bus: 10'h000, oe_n: 1'b1, nib: 6'h00, sync: 1'b0};
            ph_q <= 1'b0;
            hold_q <= 6'h00;
        end else begin
            rxo_q.oe_n <= !(rx_on && !rf.tri_st);
            rxo_q.bus <= (rx_empty || st_q != RX_DRIVE) ? 10'h000
                : rxw;
            ph_q <= lk_mode_q && !ph_q;
            rxo_q.sync <= ph_q ^ rf.inv;
            if (!ph_q) begin
                rxo_q.nib <= rf.lsf ? ls_of(rxw, rf.five)
                    : ms_of(rxw, rf.five);
                hold_q <= rf.lsf ? ms_of(rxw, rf.five)
                    : ls_of(rxw, rf.five);
            end else begin
                rxo_q.nib <= hold_q;
            end
        end
    end

    function automatic logic [5:0] ms_of(input logic [9:0] w,
        input logic f);
        ms_of = f ? {w[9:5], 1'b0} : w[9:4];
    endfunction

    function automatic logic [5:0] ls_of(input logic [9:0] w,
        input logic f);
        ls_of = f ? {w[4:0], 1'b0} : {2'h0, w[3:0]};
    endfunction

    // Falling edge copy for the falling edge option
    always_ff @(negedge i_port_clk) begin
        rxo_neg_q <= rxo_q;
    end

    assign rxo = rf.neg ? rxo_neg_q : rxo_q;
    assign o_shared_data_bus = rxo.bus;
    assign o_shared_data_bus_oe_n = rxo.oe_n || lk_mode_q;
    assign o_rx_nibble = rxo.nib;
    assign o_receive_nibble_sync = rxo.sync;

    // Receive clock out, full duplex only
    assign o_receive_port_clock = !lk_mode_q ? 1'b0
        : clk_q[`DDP_B_OSC] ? i_oscillator_input
        : !clk_q[`DDP_B_CKDIS] && (i_port_clk ^ clk_q[`DDP_B_CKINV]);

    // ==========================================
    // Checks
    oe_rel_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q) !rx_on |=> rxo_q.oe_n)
        else $error("bus driven with receive gate off");
    cap_gate_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (!lk_mode_q && tx_push && fl_q == 6'd0) |-> (txg && !rxg))
        else $error("capture outside transmit window");
    flush_load_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (!lk_mode_q && $fell(txg)) |=> fl_q == 6'd33)
        else $error("flush count not loaded");
    rx_lat_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (st_q == RX_OFF && rx_on) ##1 rx_on [*5] |=> st_q == RX_DRIVE)
        else $error("receive data not valid after six clocks");
    no_loop_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (st_q == RX_DRIVE && rxg) |-> (!tx_push || lk_mode_q
        || fl_q != 6'd0))
        else $error("driven word captured");
    fd_join_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (lk_mode_q && s) |-> tx_push)
        else $error("second nibble did not form a word");
    rx_sync_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        (lk_mode_q && $past(lk_mode_q, 2) && $stable(rf.inv)
        && $past(lk_rst_b_q, 3))
        |-> rxo_q.sync != $past(rxo_q.sync))
        else $error("receive sync not alternating");
    gain_ld_a: assert property (@(posedge i_port_clk)
        disable iff (!lk_rst_b_q)
        gld |=> rgain_q == $past(tp.nib))
        else $error("gain not loaded from port");
    reg_wr_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_reg_wr && i_reg_addr == `DDP_OFS_TXF)
        |=> txf_q == $past(i_reg_wdata))
        else $error("format register not written");
endmodule // ddp_port

// File: testbench/ddp_asic_model.sv
// Purpose: Baseband partner driving the pins of the duplex data port
// Assumes: Pins change just after rising link clock edges
// Notes: Bus level resolution is done in the bench
`timescale 1ns/1ps
module ddp_asic_model (
    input wire logic i_port_clk,
    output logic [9:0] o_bus,
    output logic o_bus_en,
    output logic o_tx_gate,
    output logic o_rx_gate,
    output logic [5:0] o_nib,
    output logic o_sync,
    output logic o_gain
);
    // ==========================================
    // Idle pin levels
    initial begin
        o_bus = 10'h000;
        o_bus_en = 1'b0;
        o_tx_gate = 1'b0;
        o_rx_gate = 1'b0;
        o_nib = 6'h00;
        o_sync = 1'b0;
        o_gain = 1'b0;
    end

    // ==========================================
    // Gate levels; bus driven only with transmit gate alone
    task automatic set_gates(input logic tx, input logic rx);
        @(posedge i_port_clk);
        o_tx_gate <= tx;
        o_rx_gate <= rx;
        o_bus_en <= tx & ~rx;
    endtask

    // One half-duplex word on the next clock
    task automatic hd_send(input logic [9:0] w);
        set_gates(1'b1, 1'b0);
        o_bus <= w;
    endtask

    // Two nibbles of one word, then sync back low
    task automatic fd_pair(input logic [5:0] a, input logic [5:0] b);
        @(posedge i_port_clk);
        o_sync <= 1'b0;
        o_nib <= a;
        @(posedge i_port_clk);
        o_sync <= 1'b1;
        o_nib <= b;
        @(posedge i_port_clk);
        o_sync <= 1'b0;
        o_nib <= 6'h00;
    endtask

    // Gain strobe with sync low, value held two clocks
    task automatic fd_gain(input logic [5:0] g);
        @(posedge i_port_clk);
        o_sync <= 1'b0;
        o_nib <= g;
        o_gain <= 1'b1;
        repeat (2) @(posedge i_port_clk);
        o_gain <= 1'b0;
        o_nib <= 6'h00;
    endtask
endmodule // ddp_asic_model

// File: testbench/ddp_port_bench.sv
// Purpose: Self-checking bench of the duplex data port
// Assumes: Core clock 25 ns, link and oscillator clocks 32 ns
// Notes: Tests are sequences of register and pin tasks
`timescale 1ns/1ps
`include "ddp_params.svh"
module ddp_port_bench import ddp_pkg::*;;
    localparam logic [4:0] OFS[6] = '{`DDP_OFS_CLK, `DDP_OFS_GAIN,
        `DDP_OFS_TXF, `DDP_OFS_RXF, `DDP_OFS_DRV, 5'h1F};
    localparam logic [7:0] RST[6] = '{`DDP_RST_REG, `DDP_RST_GAIN,
        `DDP_RST_REG, `DDP_RST_REG, `DDP_RST_REG, 8'h00};
    localparam logic [7:0] TXF[3] = '{8'h00, 8'h01, 8'h02};
    localparam logic [9:0] HDW[3] = '{10'h000, 10'h3FF, 10'h155};
    localparam logic [7:0] CKC[4] = '{8'h02, 8'h04, 8'h01, 8'h00};
    localparam logic [7:0] FDF[4] = '{8'h00, 8'h08, 8'h04, 8'h01};
    logic core_clk = 1'b0;
    logic port_clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst_b = 1'b0;
    logic mode = 1'b0;
    logic reg_wr = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [9:0] bus_dev, bus_asic, bus_wire;
    logic oe_n, bus_en, tx_gate, rx_gate, sync_tx, gain, sync_rx, rx_clk;
    logic low_drive, rx_ready;
    logic [5:0] nib_tx, nib_rx, gain_amp;
    ddp_word_t tx_word;
    ddp_word_t rx_word = '0;
    logic [9:0] txq[$];
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // ==========================================
    // Clocks with unrelated phases
    always #12.5 core_clk = ~core_clk;
    initial #3.3 forever #16 port_clk = ~port_clk;
    initial #9.1 forever #16 osc_clk = ~osc_clk;

    // Bus level: device, partner, or inverse of last partner value
    assign bus_wire = !oe_n ? bus_dev : bus_en ? bus_asic : ~bus_asic;

    ddp_port dut (
        .i_core_clk(core_clk),
        .i_rst_b(rst_b),
        .i_port_clk(port_clk),
        .i_oscillator_input(osc_clk),
        .i_mode_strap(mode),
        .i_reg_wr(reg_wr),
        .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata),
        .i_shared_data_bus(bus_wire),
        .o_shared_data_bus(bus_dev),
        .o_shared_data_bus_oe_n(oe_n),
        .i_transmit_gate(tx_gate),
        .i_receive_gate(rx_gate),
        .i_tx_nibble(nib_tx),
        .i_transmit_nibble_sync(sync_tx),
        .i_gain_strobe(gain),
        .o_rx_nibble(nib_rx),
        .o_receive_nibble_sync(sync_rx),
        .o_receive_port_clock(rx_clk),
        .o_low_drive(low_drive),
        .o_receive_gain_amp(gain_amp),
        .o_tx_word(tx_word),
        .i_tx_ready(1'b1),
        .i_rx_word(rx_word),
        .o_rx_ready(rx_ready)
    );

    ddp_asic_model asic (
        .i_port_clk(port_clk),
        .o_bus(bus_asic),
        .o_bus_en(bus_en),
        .o_tx_gate(tx_gate),
        .o_rx_gate(rx_gate),
        .o_nib(nib_tx),
        .o_sync(sync_tx),
        .o_gain(gain)
    );

    // ==========================================
    // Collect transmit words, bound the run
    always @(posedge core_clk) begin
        if (tx_word.valid === 1'b1)
            txq.push_back(tx_word.data);
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("Error at %0t: run timed out", $time);
            finish_test();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic lwait(input int n);
        repeat (n) @(posedge port_clk);
        @(negedge port_clk);
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        lwait(4);
    endtask

    task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    task automatic push_rx(input logic [9:0] d);
        @(posedge core_clk);
        rx_word <= {1'b1, d};
        do @(posedge core_clk); while (rx_ready !== 1'b1);
        rx_word <= '0;
    endtask

    task automatic do_reset(input logic m);
        @(posedge core_clk);
        rst_b <= 1'b0;
        mode <= m;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        lwait(4);
    endtask

    // Expected full-duplex word from two nibbles and a format byte
    function automatic logic [9:0] fd_word(input logic [7:0] f,
        input logic [5:0] a, input logic [5:0] b);
        logic [9:0] w;
        if (f[3])
            w = {a[5:1], b[5:1]};
        else if (f[2])
            w = {b, a[3:0]};
        else
            w = {a, b[3:0]};
        return f[0] ? w ^ 10'h200 : w;
    endfunction

    // ==========================================
    // Test sequence
    initial begin
        logic [7:0] rd;
        logic [9:0] w;
        logic e;
        int n;
        do_reset(1'b0);
        for (int i = 0; i < 6; i++) begin
            reg_read(OFS[i], rd);
            check(rd, RST[i]);
        end
        reg_write(`DDP_OFS_DRV, 8'h80);
        reg_read(`DDP_OFS_DRV, rd);
        check(rd, 8'h80);
        check(low_drive, 1'b1);
        $display("Test registers done");
        // Half-duplex burst, then flush, per format
        foreach (TXF[k]) begin
            reg_write(`DDP_OFS_TXF, TXF[k]);
            txq.delete();
            foreach (HDW[i])
                asic.hd_send(HDW[i]);
            asic.set_gates(1'b0, 1'b0);
            lwait(45);
            check(16'(txq.size()), 16'd36);
            for (int i = 0; i < 3; i++)
                check(txq[i], HDW[i] ^ (TXF[k][0] ? 10'h000 : 10'h200));
            w = 10'h000;
            for (int i = 3; i < txq.size(); i++)
                w = w | txq[i];
            check(w, 10'h000);
        end
        $display("Test half duplex transmit done");
        // Half-duplex receive, no loop back, release
        push_rx(10'h155);
        asic.set_gates(1'b0, 1'b1);
        n = 0;
        while (!(oe_n === 1'b0 && bus_dev === 10'h355) && n < 12) begin
            @(negedge port_clk);
            n++;
        end
        check(bus_dev, 10'h355);
        check(oe_n, 1'b0);
        asic.set_gates(1'b1, 1'b1);
        lwait(3);
        txq.delete();
        lwait(8);
        check(16'(txq.size()), 16'd0);
        asic.set_gates(1'b0, 1'b0);
        lwait(3);
        check(oe_n, 1'b1);
        lwait(40);
        reg_write(`DDP_OFS_RXF, 8'h20);
        asic.set_gates(1'b0, 1'b1);
        lwait(8);
        check(oe_n, 1'b1);
        asic.set_gates(1'b0, 1'b0);
        reg_write(`DDP_OFS_RXF, 8'h10);
        lwait(4);
        check(oe_n, 1'b0);
        reg_write(`DDP_OFS_RXF, 8'h00);
        lwait(3);
        check(oe_n, 1'b1);
        $display("Test half duplex receive done");
        // Full duplex: clock output options
        do_reset(1'b1);
        check(oe_n, 1'b1);
        foreach (CKC[k]) begin
            reg_write(`DDP_OFS_CLK, CKC[k]);
            for (int i = 0; i < 8; i++) begin
                @(negedge core_clk);
                e = CKC[k][2] ? osc_clk : port_clk ^ CKC[k][1];
                check(rx_clk, CKC[k][0] ? 1'b0 : e);
            end
        end
        // Full duplex transmit formats, repeated word while sync low
        foreach (FDF[k]) begin
            reg_write(`DDP_OFS_TXF, FDF[k]);
            txq.delete();
            asic.fd_pair(6'h2B, 6'h17);
            lwait(8);
            check(txq[$], fd_word(FDF[k], 6'h2B, 6'h17));
            check(txq[$-1], fd_word(FDF[k], 6'h2B, 6'h17));
        end
        asic.fd_gain(6'h15);
        lwait(4);
        check(gain_amp, 6'h15);
        // Full duplex receive nibbles
        push_rx(10'h2A5);
        n = 0;
        w = 10'h000;
        repeat (30) begin
            @(negedge port_clk);
            if (n == 1) begin
                w[3:0] = nib_rx[3:0];
                check(sync_rx, 1'b1);
                n = 2;
            end
            if (sync_rx === 1'b0 && nib_rx === 6'h2A && n == 0) begin
                w[9:4] = 6'h2A;
                n = 1;
            end
        end
        check(w, 10'h2A5);
        $display("Test full duplex done");
        finish_test();
    end
endmodule // ddp_port_bench
